// *** hdl/uiv_pkg.sv ***
package uiv_pkg;
  localparam logic [31:0] HDR_VERSION_ONE = 32'h0000_0001;
  // header byte offsets
  localparam logic [31:0] OFS_VERSION = 32'h0000_0000;
  localparam logic [31:0] OFS_IDENTITY = 32'h0000_000c;
  localparam logic [31:0] OFS_MASK = 32'h0000_0018;
  localparam logic [31:0] OFS_TOTAL = 32'h0000_001c;
  localparam logic [31:0] OFS_PAYLOAD = 32'h0000_0020;
  // extended table, relative to the payload size
  localparam logic [31:0] OFS_EXT_COUNT = 32'h0000_0030;
  localparam logic [31:0] OFS_EXT_SUM = 32'h0000_0034;
  localparam logic [31:0] OFS_EXT_RSVD = 32'h0000_0038;
  localparam logic [31:0] OFS_ENTRY_ID = 32'h0000_0044;
  localparam logic [31:0] OFS_ENTRY_MASK = 32'h0000_0048;
  localparam logic [31:0] OFS_ENTRY_SUM = 32'h0000_004c;
  localparam logic [31:0] ENTRY_BYTES = 32'h0000_000c;
  localparam logic [31:0] EXT_HDR_BYTES = 32'h0000_0014;
  localparam logic [2:0] EXT_HDR_WORDS = 3'h5;
  localparam logic [1:0] ENTRY_WORDS = 2'h3;
  localparam logic [1:0] BYTE_SHIFT = 2'h2;
  localparam logic [31:0] DEFAULT_WORDS = 32'h0000_0200;
  localparam logic [31:0] DEFAULT_PAYLOAD = 32'h0000_07d0;
  localparam logic [31:0] KB_MASK = 32'h0000_03ff;
  localparam logic [31:0] SUM_GOOD = 32'h0000_0000;
  // platform register
  localparam logic [31:0] PLAT_REG_ADDR = 32'h0000_0017;
  localparam int PLAT_LSB = 50;
  localparam int PLAT_MSB = 52;
  localparam int PLAT_W = 3;

  typedef enum logic [2:0] {
    UIV_CAUSE_NONE = 3'h0,
    UIV_CAUSE_VERSION = 3'h1,
    UIV_CAUSE_SIZE = 3'h2,
    UIV_CAUSE_CHECKSUM = 3'h3,
    UIV_CAUSE_EXT_TABLE = 3'h4,
    UIV_CAUSE_IDENTITY = 3'h5,
    UIV_CAUSE_PLATFORM = 3'h6
  } uiv_cause_type;

  typedef struct packed {
    logic done;
    logic accept;
    logic reject;
    uiv_cause_type cause;
  } uiv_verdict_type;

  function automatic logic [29:0] uiv_word(input logic [31:0] ofs);
    return ofs[31:2];
  endfunction
endpackage

// *** hdl/uiv_validator.sv ***
// Notes on behaviour
// - extended table optional, used when present and the primary identity misses
// - extended header is count, checksum, 12 reserved
// - entry count bounds the entry scan exactly
// - extended table valid only when words sum zero
// - count, checksum, reserved at payload plus 48/52/56
// - entry n at payload plus 68/72/76 plus 12n
// - accept only when an identity word matches
// - version 1: primary first, then extended scan
// - platform bits 52:50 select support mask bit
// - each set mask bit is one supported platform
// - platform register 017h, 64-bit, read-only, whole reads
// - primary mask test, else matched entry mask
// - image checksum is unsigned modulo 2^32 word sum
// - zero sum intact, nonzero rejects as corrupt
// - zero payload means 2000 bytes, else total/4 words
// - loop defaults to 512 words
module uiv_validator #(
  parameter int ADDR_W = 32
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire logic [ADDR_W-1:0] image_base,
  input wire logic [31:0] cpu_identity_word,
  input wire logic [uiv_pkg::PLAT_W-1:0] platform_pins,
  output logic mem_rd_req,
  output logic [ADDR_W-1:0] mem_rd_addr,
  input wire logic mem_rd_valid,
  input wire logic [31:0] mem_rd_data,
  input wire logic model_register_read,
  input wire logic [31:0] mreg_addr,
  output logic mreg_rd_ack,
  output logic mreg_rd_err,
  output logic [63:0] mreg_rd_data,
  output logic busy,
  output uiv_pkg::uiv_verdict_type verdict
);

  typedef enum logic [1:0] {
    UIV_IDLE = 2'b00,
    UIV_FETCH = 2'b01,
    UIV_WAIT = 2'b10,
    UIV_JUDGE = 2'b11
  } uiv_state_type;

  localparam int PLAT_W_L = uiv_pkg::PLAT_W;
  uiv_state_type state;
  logic [PLAT_W_L-1:0] pin_s1;
  logic [PLAT_W_L-1:0] pin_s2;
  logic [PLAT_W_L-1:0] pin_s3;
  logic [PLAT_W_L-1:0] platform_field;
  logic [63:0] platform_type_id;
  logic [29:0] idx;
  logic [31:0] n_words;
  logic [31:0] running_sum;
  logic [31:0] header_format_version;
  logic [31:0] prim_mask;
  logic [31:0] image_total_bytes;
  logic [31:0] payload_bytes;
  logic prim_hit;
  // set when the loop length comes from the total size
  logic size_from_total;
  logic ext_active;
  logic ext_done;
  logic [29:0] ext_base_w;
  logic [2:0] ext_hcnt;
  logic [1:0] ext_phase;
  logic [31:0] extra_entry_count;
  logic [31:0] ext_n;
  logic [31:0] ext_sum;
  logic ext_cur_hit;
  logic ext_hit;
  logic [31:0] ext_mask;
  logic [31:0] sel_bit;
  logic last_word;
  logic in_ext;
  logic [31:0] w;

  assign w = mem_rd_data;
  // one-hot platform bit from a binary field 0..7
  assign sel_bit = 32'h0000_0001 << platform_field;
  // loop length may shrink once the payload word arrives
  assign last_word = ({2'b00, idx} + 32'h0000_0001) >= n_words;
  assign in_ext = ext_active && !ext_done && idx >= ext_base_w;

  // strap pins: three stages, change only when two and three agree
  // stage one feeds stage two only, to contain metastability
  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      platform_field <= '0;
    end else begin
      pin_s1 <= platform_pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        platform_field <= pin_s3;
      end
    end
  end

  // reserved bits read as zero
  always_comb begin
    platform_type_id = 64'h0000_0000_0000_0000;
    platform_type_id[uiv_pkg::PLAT_MSB:uiv_pkg::PLAT_LSB] = platform_field;
  end

  // read-only: only a whole read at its address answers with data
  // unmapped reads still ack, with err, so firmware never stalls
  always_ff @(posedge mclk) begin
    if (reset) begin
      mreg_rd_ack <= 1'b0;
      mreg_rd_err <= 1'b0;
      mreg_rd_data <= 64'h0000_0000_0000_0000;
    end else begin
      mreg_rd_ack <= model_register_read;
      mreg_rd_err <= model_register_read &&
                     mreg_addr != uiv_pkg::PLAT_REG_ADDR;
      if (model_register_read &&
          mreg_addr == uiv_pkg::PLAT_REG_ADDR) begin
        mreg_rd_data <= platform_type_id;
      end else begin
        mreg_rd_data <= 64'h0000_0000_0000_0000;
      end
    end
  end

  // sequencer: one outstanding read at a time
  // one read in flight keeps the memory side simple, at a latency cost
  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= UIV_IDLE;
      idx <= '0;
      mem_rd_req <= 1'b0;
      mem_rd_addr <= '0;
      busy <= 1'b0;
    end else begin
      mem_rd_req <= 1'b0;
      unique case (state)
        UIV_IDLE: begin
          if (start) begin
            idx <= '0;
            busy <= 1'b1;
            state <= UIV_FETCH;
          end
        end
        UIV_FETCH: begin
          mem_rd_req <= 1'b1;
          // supplier keeps the base 16-byte aligned
          mem_rd_addr <= image_base +
                         ADDR_W'({idx, 2'b00});
          state <= UIV_WAIT;
        end
        UIV_WAIT: begin
          if (mem_rd_valid) begin
            idx <= idx + 30'h1;
            state <= last_word ? UIV_JUDGE : UIV_FETCH;
          end
        end
        UIV_JUDGE: begin
          busy <= 1'b0;
          state <= UIV_IDLE;
        end
      endcase
    end
  end

  // header capture and whole-image sum
  always_ff @(posedge mclk) begin
    if (reset || (state == UIV_IDLE && start)) begin
      running_sum <= 32'h0000_0000;
      n_words <= uiv_pkg::DEFAULT_WORDS;
      header_format_version <= 32'h0000_0000;
      prim_mask <= 32'h0000_0000;
      image_total_bytes <= 32'h0000_0000;
      payload_bytes <= 32'h0000_0000;
      prim_hit <= 1'b0;
      size_from_total <= 1'b0;
    end else if (state == UIV_WAIT && mem_rd_valid) begin
      running_sum <= running_sum + w;
      if (idx == uiv_pkg::uiv_word(uiv_pkg::OFS_VERSION)) begin
        header_format_version <= w;
      end
      if (idx == uiv_pkg::uiv_word(uiv_pkg::OFS_IDENTITY)) begin
        prim_hit <= w == cpu_identity_word;
      end
      if (idx == uiv_pkg::uiv_word(uiv_pkg::OFS_MASK)) begin
        prim_mask <= w;
      end
      if (idx == uiv_pkg::uiv_word(uiv_pkg::OFS_TOTAL)) begin
        image_total_bytes <= w;
      end
      if (idx == uiv_pkg::uiv_word(uiv_pkg::OFS_PAYLOAD)) begin
        // zero payload: 2000 bytes, loop stays at 512 words
        payload_bytes <= (w == 32'h0000_0000) ?
                         uiv_pkg::DEFAULT_PAYLOAD : w;
        size_from_total <= w != 32'h0000_0000;
        if (w != 32'h0000_0000) begin
          n_words <= image_total_bytes >> uiv_pkg::BYTE_SHIFT;
        end
      end
    end
  end

  // extended table walk in the same pass
  // entry checksums only feed the table sum, none is checked alone
  always_ff @(posedge mclk) begin
    if (reset || (state == UIV_IDLE && start)) begin
      ext_active <= 1'b0;
      ext_done <= 1'b0;
      ext_base_w <= '0;
      ext_hcnt <= 3'h0;
      ext_phase <= 2'h0;
      extra_entry_count <= 32'h0000_0000;
      ext_n <= 32'h0000_0000;
      ext_sum <= 32'h0000_0000;
      ext_cur_hit <= 1'b0;
      ext_hit <= 1'b0;
      ext_mask <= 32'h0000_0000;
    end else if (state == UIV_WAIT && mem_rd_valid) begin
      if (idx == uiv_pkg::uiv_word(uiv_pkg::OFS_PAYLOAD) &&
          w != 32'h0000_0000) begin
        // table present only past the payload
        ext_active <= image_total_bytes >
                      (w + uiv_pkg::OFS_EXT_COUNT);
        ext_base_w <=
          uiv_pkg::uiv_word(w + uiv_pkg::OFS_EXT_COUNT);
      end
      if (in_ext) begin
        ext_sum <= ext_sum + w;
        if (ext_hcnt < uiv_pkg::EXT_HDR_WORDS) begin
          // count, checksum, then reserved words
          ext_hcnt <= ext_hcnt + 3'h1;
          if (ext_hcnt == 3'h0) begin
            extra_entry_count <= w;
          end
          if (ext_hcnt == uiv_pkg::EXT_HDR_WORDS - 3'h1 &&
              extra_entry_count == 32'h0000_0000) begin
            ext_done <= 1'b1;
          end
        end else begin
          // identity, support mask, entry checksum
          ext_phase <= (ext_phase == uiv_pkg::ENTRY_WORDS - 2'h1) ?
                       2'h0 : ext_phase + 2'h1;
          if (ext_phase == 2'h0) begin
            ext_cur_hit <= !prim_hit && !ext_hit &&
                           w == cpu_identity_word;
          end
          if (ext_phase == 2'h1 && ext_cur_hit) begin
            ext_hit <= 1'b1;
            ext_mask <= w;
          end
          if (ext_phase == uiv_pkg::ENTRY_WORDS - 2'h1) begin
            ext_n <= ext_n + 32'h0000_0001;
            if (ext_n + 32'h0000_0001 == extra_entry_count) begin
              ext_done <= 1'b1;
            end
          end
        end
      end
    end
  end

  // verdict, one-cycle done pulse
  // causes in fixed priority: the first failing test wins
  always_ff @(posedge mclk) begin
    if (reset) begin
      verdict <= '0;
    end else if (state == UIV_JUDGE) begin
      verdict.done <= 1'b1;
      verdict.accept <= 1'b0;
      verdict.reject <= 1'b1;
      if (header_format_version != uiv_pkg::HDR_VERSION_ONE) begin
        verdict.cause <= uiv_pkg::UIV_CAUSE_VERSION;
      end else if (size_from_total &&
                   (image_total_bytes & uiv_pkg::KB_MASK) != '0) begin
        verdict.cause <= uiv_pkg::UIV_CAUSE_SIZE;
      end else if (running_sum != uiv_pkg::SUM_GOOD) begin
        verdict.cause <= uiv_pkg::UIV_CAUSE_CHECKSUM;
      end else if (ext_active && !prim_hit &&
                   (!ext_done || ext_sum != uiv_pkg::SUM_GOOD)) begin
        verdict.cause <= uiv_pkg::UIV_CAUSE_EXT_TABLE;
      end else if (!prim_hit && !ext_hit) begin
        verdict.cause <= uiv_pkg::UIV_CAUSE_IDENTITY;
      end else if ((prim_mask & sel_bit) != '0 ||
                   (ext_hit && (ext_mask & sel_bit) != '0)) begin
        // any set mask bit is one supported platform
        verdict.accept <= 1'b1;
        verdict.reject <= 1'b0;
        verdict.cause <= uiv_pkg::UIV_CAUSE_NONE;
      end else begin
        verdict.cause <= uiv_pkg::UIV_CAUSE_PLATFORM;
      end
    end else begin
      verdict.done <= 1'b0;
    end
  end

endmodule

// *** tb/tb_update_image_validator.sv ***
module tb_update_image_validator;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset = 1, start = 0, model_register_read = 0;
  logic [31:0] image_base = 32'h100, cpu_identity_word = 0, mreg_addr = 0;
  logic [2:0] platform_pins = 0;
  logic [1:0] lat = 0;
  logic mem_rd_req, mem_rd_valid, mreg_rd_ack, mreg_rd_err, busy;
  logic [31:0] mem_rd_addr, mem_rd_data, x = 32'h5, img [0:511];
  logic [63:0] mreg_rd_data;
  uiv_pkg::uiv_verdict_type verdict;
  int n_fail = 0, n_tests = 0, n_reads = 0;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (mem_rd_req) n_reads <= n_reads + 1;
  uiv_validator dut (.mclk(mclk), .reset(reset), .start(start),
    .image_base(image_base), .cpu_identity_word(cpu_identity_word),
    .platform_pins(platform_pins), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid),
    .mem_rd_data(mem_rd_data), .model_register_read(model_register_read),
    .mreg_addr(mreg_addr), .mreg_rd_ack(mreg_rd_ack),
    .mreg_rd_err(mreg_rd_err), .mreg_rd_data(mreg_rd_data), .busy(busy),
    .verdict(verdict));
  uiv_mem_model partner (.mclk(mclk), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .lat(lat), .mem_rd_valid(mem_rd_valid),
    .mem_rd_data(mem_rd_data));
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic report_and_stop();
    $display("failures %0d checks %0d", n_fail, n_tests);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check_word(input logic [63:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_verdict(input logic [5:0] g, e);
    check_word(64'(g), 64'(e));
  endtask
  // image in words; whole kilobytes except the 1028-byte size case, 16-byte aligned base
  task automatic mk(input int ver, pay, tot, pid, pm, n, mid, em, bad);
    int w, e;
    logic [31:0] s, b;
    b = 32'h1 << platform_pins;
    w = pay == 0 ? 512 : tot / 4;
    foreach (img[i]) img[i] = rnd();
    img[0] = 32'(ver);
    img[3] = pid != 0 ? cpu_identity_word : ~cpu_identity_word;
    img[6] = pm != 0 ? img[6] | b : img[6] & ~b;
    img[7] = 32'(tot);
    img[8] = 32'(pay);
    if (pay != 0) begin
      e = (pay + 48) / 4;
      img[e] = 32'(n);
      // one entry past the count, to show the count bounds the scan
      for (int k = 0; k <= n; k++) begin
        img[e+5+3*k] = k == mid ? cpu_identity_word : ~cpu_identity_word;
        img[e+6+3*k] = em != 0 ? img[e+6+3*k] | b : img[e+6+3*k] & ~b;
      end
      s = 0;
      for (int i = 0; i < 5 + 3 * n; i++) s += img[e+i];
      img[e+1] -= s - 32'(bad == 1);
    end
    s = 0;
    for (int i = 0; i < w; i++) s += img[i];
    img[1] -= s - 32'(bad == 2);
    foreach (img[i]) partner.mem[64+i] = img[i];
  endtask
  function automatic logic [2:0] ref_cause();
    int w, e, c;
    logic [31:0] s, m;
    logic hit;
    w = img[8] == 0 ? 512 : img[7] / 4;
    s = 0;
    for (int i = 0; i < w; i++) s += img[i];
    m = img[6];
    hit = img[3] == cpu_identity_word;
    if (img[0] != 32'h1) return 3'h1;
    if (img[8] != 0 && img[7][9:0] != 0) return 3'h2;
    if (s != 0) return 3'h3;
    if (!hit && img[8] != 0 && img[7] > img[8] + 48) begin
      e = (img[8] + 48) / 4;
      c = img[e];
      s = 0;
      for (int i = 0; i < 5 + 3 * c; i++) s += img[e+i];
      if (s != 0 || e + 5 + 3 * c > w) return 3'h4;
      for (int k = c - 1; k >= 0; k--) begin
        if (img[e+5+3*k] == cpu_identity_word) begin
          hit = 1;
          m = img[e+6+3*k];
        end
      end
    end
    if (!hit) return 3'h5;
    if (!img[6][platform_pins] && !m[platform_pins]) return 3'h6;
    return 3'h0;
  endfunction
  task automatic run(input int ver, pay, tot, pid, pm, n, mid, em, bad);
    logic [2:0] c;
    int r0;
    @(posedge mclk);
    cpu_identity_word <= rnd();
    platform_pins <= 3'(rnd());
    lat <= 2'(rnd());
    repeat (6) @(posedge mclk);
    mk(ver, pay, tot, pid, pm, n, mid, em, bad);
    c = ref_cause();
    r0 = n_reads;
    start <= 1'b1;
    @(posedge mclk) start <= 1'b0;
    for (int i = 0; i < 20000 && verdict.done !== 1'b1; i++)
      @(posedge mclk) #1;
    check_verdict(verdict, {1'b1, c == 3'h0, c != 3'h0, c});
    if (c > 3'h2)
      check_word(64'(n_reads - r0), pay == 0 ? 512 : tot / 4);
  endtask
  task automatic rd(input logic [31:0] a, input logic [63:0] d, input logic e);
    @(posedge mclk);
    model_register_read <= 1'b1;
    mreg_addr <= a;
    @(posedge mclk) model_register_read <= 1'b0;
    #1 check_word(mreg_rd_data, d);
    check_word({mreg_rd_ack, mreg_rd_err}, {1'b1, e});
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    for (int p = 0; p < 8; p++) begin
      platform_pins <= 3'(p);
      repeat (6) @(posedge mclk);
      rd(32'h17, 64'(p) << 50, 1'b0);
    end
    rd(32'h18, 64'h0, 1'b1);
    run(1, 0, 0, 1, 1, 0, 0, 0, 0);
    run(1, 0, 0, 1, 1, 0, 0, 0, 2);
    run(2, 0, 0, 1, 1, 0, 0, 0, 0);
    run(1, 512, 1024, 0, 0, 2, 1, 1, 0);
    run(1, 512, 1024, 0, 0, 2, 1, 1, 1);
    run(1, 512, 1028, 1, 1, 0, 0, 0, 0);
    run(1, 0, 0, 0, 1, 0, 0, 0, 0);
    run(1, 0, 0, 1, 0, 0, 0, 0, 0);
    run(1, 512, 1024, 0, 1, 2, 2, 1, 0);
    report_and_stop();
  end
  initial begin
    #400us;
    n_fail++;
    report_and_stop();
  end
endmodule

// *** tb/uiv_mem_model.sv ***
module uiv_mem_model (
  input logic mclk,
  input logic mem_rd_req,
  input logic [31:0] mem_rd_addr,
  input logic [1:0] lat,
  output logic mem_rd_valid,
  output logic [31:0] mem_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:1023];
  logic [31:0] a = 32'h0;
  int cnt = 0;
  initial begin
    mem_rd_valid = 1'b0;
    mem_rd_data = 32'h0;
  end
  // answers 1 to 4 cycles late; idle bus toggles so no stale word shows
  always @(posedge mclk) begin
    mem_rd_valid <= 1'b0;
    mem_rd_data <= ~mem_rd_data;
    if (mem_rd_req) begin
      a <= mem_rd_addr;
      cnt <= lat + 1;
    end else if (cnt == 1) begin
      mem_rd_valid <= 1'b1;
      mem_rd_data <= mem[a[11:2]];
      cnt <= 0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule

// *** tb/uiv_validator_assertions.sv ***
module uiv_checker #(
  parameter int ADDR_W = 32
) (
  input logic mclk,
  input logic reset,
  input logic start,
  input logic [ADDR_W-1:0] image_base,
  input logic [31:0] cpu_identity_word,
  input logic [uiv_pkg::PLAT_W-1:0] platform_pins,
  input logic mem_rd_req,
  input logic [ADDR_W-1:0] mem_rd_addr,
  input logic mem_rd_valid,
  input logic [31:0] mem_rd_data,
  input logic model_register_read,
  input logic [31:0] mreg_addr,
  input logic mreg_rd_ack,
  input logic mreg_rd_err,
  input logic [63:0] mreg_rd_data,
  input logic busy,
  input uiv_pkg::uiv_verdict_type verdict
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  a_req_one_cycle: assert property (mem_rd_req |=> !mem_rd_req)
    else $error("read request longer than one cycle");
  a_start_sets_busy: assert property (start && !busy |=> busy)
    else $error("busy not raised after start");
  a_first_word: assert property (start && !busy |=> ##1 mem_rd_req
    && mem_rd_addr == image_base)
    else $error("first read not at image base");
  a_idle_no_req: assert property (!busy |-> !mem_rd_req)
    else $error("read issued while idle");
  a_done_pulse: assert property (verdict.done |=> !verdict.done)
    else $error("verdict done longer than one cycle");
  a_single_verdict: assert property (verdict.done |->
    (verdict.accept ^ verdict.reject) && $past(busy) && !busy
    && verdict.accept == (verdict.cause == uiv_pkg::UIV_CAUSE_NONE))
    else $error("inconsistent verdict");
  a_reg_ack_next: assert property (model_register_read |=>
    mreg_rd_ack && mreg_rd_err == ($past(mreg_addr) != uiv_pkg::PLAT_REG_ADDR))
    else $error("register read answer wrong");
  a_reg_data_shape: assert property (mreg_rd_ack |->
    mreg_rd_data[63:53] == 11'h0 && mreg_rd_data[49:0] == 50'h0
    && (!mreg_rd_err || mreg_rd_data == 64'h0))
    else $error("register data outside platform field");
  c_accept: cover property (verdict.done && verdict.accept);
  c_sum_bad: cover property (verdict.cause == uiv_pkg::UIV_CAUSE_CHECKSUM);
  c_reg_err: cover property (mreg_rd_err);
endmodule

bind uiv_validator uiv_checker #(.ADDR_W(ADDR_W)) chk (.mclk(mclk),
  .reset(reset), .start(start), .image_base(image_base),
  .cpu_identity_word(cpu_identity_word), .platform_pins(platform_pins),
  .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
  .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
  .model_register_read(model_register_read), .mreg_addr(mreg_addr),
  .mreg_rd_ack(mreg_rd_ack), .mreg_rd_err(mreg_rd_err),
  .mreg_rd_data(mreg_rd_data), .busy(busy), .verdict(verdict));
